// File: spf_front_end.sv
// serial bus slave front end and page buffer sequencer of the flash
`timescale 1ns/1ns
module spf_front_end
   import spf_pkg::*;
(
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic SCK_IN,
   input wire logic SDI_IN,
   input wire logic CS_N_IN,
   input wire logic HW_RESET_N_IN,
   input wire logic WP_N_IN,
   input wire logic [7:0] ARR_RDATA_IN,
   output logic SDO_OUT,
   output logic SDO_OE_OUT,
   output logic WIP_OUT,
   output spf_arr_req_s ARR_REQ_OUT
);
   //==================================================================
   // pin edge detection
   logic sck_prev;
   logic cs_prev;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic run;
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         sck_prev <= 1'b0;
         cs_prev <= 1'b1;
      end
      else
      begin
         sck_prev <= SCK_IN;
         cs_prev <= CS_N_IN;
      end
   end
   // clock idle level does not matter: only edges are used (see RQ8)
   assign sck_rise = SCK_IN & ~sck_prev;
   assign sck_fall = ~SCK_IN & sck_prev;
   assign cs_fall = ~CS_N_IN & cs_prev;
   assign cs_rise = CS_N_IN & ~cs_prev;
   assign run = HW_RESET_N_IN;

   //==================================================================
   // arming: nothing is taken before a select falling edge
   logic armed;
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         armed <= 1'b0;
      else if (!run)
         armed <= 1'b0;
      else if (cs_fall)
         armed <= 1'b1; // see RQ4
   end

   //==================================================================
   // serial shifter and header decode
   logic [6:0] shreg;
   logic [2:0] bit_cnt;
   logic [2:0] byte_cnt;
   logic [7:0] opcode;
   logic [ADDR_W-1:0] addr;
   logic [7:0] idx;
   logic [7:0] next_byte;
   logic active;
   logic byte_done;
   spf_state_e state;
   assign active = run && armed && !CS_N_IN;
   assign next_byte = {shreg, SDI_IN}; // msb arrives first, see RQ20
   assign byte_done = active && sck_rise && (bit_cnt == 3'h7);
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         shreg <= 7'h00;
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         opcode <= 8'h00;
         addr <= '0;
      end
      else if (!run || cs_fall)
      begin
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         opcode <= 8'h00;
      end
      else if (active && sck_rise)
      begin
         shreg <= next_byte[6:0]; // see RQ2
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7)
         begin
            if (byte_cnt != DATA_PHASE)
               byte_cnt <= byte_cnt + 3'h1;
            case (byte_cnt)
               3'h0: opcode <= next_byte;
               3'h1: addr[ADDR_W-1:16] <= next_byte[4:0]; // 32 sectors only, see RQ15
               3'h2: addr[15:8] <= next_byte;
               3'h3: addr[7:0] <= next_byte;
               default: ;
            endcase
         end
      end
   end

   //==================================================================
   // page buffer: written from the bus, refilled from the array
   logic [7:0] page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] touched;
   logic is_load;
   logic [STEP_W-1:0] step;
   logic [7:0] load_idx;
   logic pp_mode;
   assign is_load = (byte_cnt >= HDR_BYTES) && (opcode == OP_PW || opcode == OP_PP);
   assign load_idx = step[8:1];
   always_ff @(posedge REF_CLK_IN)
   begin
      if (byte_done && is_load && state == ST_IDLE)
         page_buf[idx] <= next_byte; // see RQ11
      else if (state == ST_LOAD && step[0])
      begin
         // untouched bytes take the array; program may only clear bits
         if (!touched[load_idx])
            page_buf[load_idx] <= ARR_RDATA_IN; // see RQ12
         else if (pp_mode)
            page_buf[load_idx] <= page_buf[load_idx] & ARR_RDATA_IN; // see RQ13
      end
   end

   // index starts at the low address byte and wraps within the page
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         idx <= 8'h00;
         touched <= '0;
      end
      else if (state == ST_IDLE && byte_done && byte_cnt == 3'h3)
      begin
         idx <= next_byte; // see RQ11
         touched <= '0;
      end
      else if (state == ST_IDLE && byte_done && is_load)
      begin
         idx <= idx + 8'h1; // see RQ24, RQ9
         touched[idx] <= 1'b1;
      end
   end

   //==================================================================
   // command acceptance on select rise
   logic on_boundary;
   logic protected_tgt;
   logic start_ok;
   assign on_boundary = (bit_cnt == 3'h0); // see RQ21
   // lowest sector holds the 256 locked pages
   assign protected_tgt = !WP_N_IN && (addr[ADDR_W-1:16] == PROT_SECTOR); // see RQ7
   assign start_ok = run && armed && cs_rise && on_boundary && state == ST_IDLE; // see RQ23

   logic write_enable_latch;
   logic go_load;
   logic go_erase;
   assign go_load = start_ok && write_enable_latch && !protected_tgt && byte_cnt == DATA_PHASE
      && (opcode == OP_PW || opcode == OP_PP); // see RQ22
   assign go_erase = start_ok && write_enable_latch && !protected_tgt && byte_cnt == HDR_BYTES
      && (opcode == OP_PE || opcode == OP_SE); // see RQ16

   //==================================================================
   // internal cycle sequencer; reset pin aborts it at once
   logic sect_mode;
   logic pw_mode;
   logic [ADDR_W-1:0] base;
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         state <= ST_IDLE;
         step <= '0;
         pp_mode <= 1'b0;
         pw_mode <= 1'b0;
         sect_mode <= 1'b0;
         base <= '0;
      end
      else if (!run)
         state <= ST_IDLE; // see RQ6
      else
      begin
         case (state)
            ST_IDLE:
            begin
               step <= '0;
               base <= {addr[ADDR_W-1:8], 8'h00};
               pp_mode <= (opcode == OP_PP);
               pw_mode <= (opcode == OP_PW);
               sect_mode <= (opcode == OP_SE);
               if (go_load)
                  state <= ST_LOAD; // see RQ12
               else if (go_erase)
                  state <= ST_ERASE;
            end
            ST_LOAD:
            begin
               step <= step + 17'h1;
               if (step == LOAD_LAST)
               begin
                  step <= '0;
                  state <= pw_mode ? ST_ERASE : ST_PROG; // see RQ13
               end
            end
            ST_ERASE:
            begin
               step <= step + 17'h1;
               if (step == (sect_mode ? SECT_LAST : PAGE_LAST))
               begin
                  step <= '0;
                  state <= (pw_mode) ? ST_PROG : ST_IDLE;
               end
            end
            ST_PROG:
            begin
               step <= step + 17'h1;
               if (step == PAGE_LAST)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // array request; a sector erase walks the whole sector
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         ARR_REQ_OUT <= '0;
      else
      begin
         ARR_REQ_OUT.we <= 1'b0;
         ARR_REQ_OUT.wdata <= ERASED_BYTE;
         if (run && state == ST_LOAD)
            ARR_REQ_OUT.addr <= {base[ADDR_W-1:8], load_idx};
         else if (run && state == ST_ERASE)
         begin
            ARR_REQ_OUT.we <= 1'b1;
            if (sect_mode)
               ARR_REQ_OUT.addr <= {base[ADDR_W-1:16], step[15:0]};
            else
               ARR_REQ_OUT.addr <= {base[ADDR_W-1:8], step[7:0]};
         end
         else if (run && state == ST_PROG)
         begin
            ARR_REQ_OUT.we <= 1'b1;
            ARR_REQ_OUT.addr <= {base[ADDR_W-1:8], step[7:0]};
            ARR_REQ_OUT.wdata <= page_buf[step[7:0]];
         end
      end
   end

   //==================================================================
   // status: busy flag and write enable latch
   logic busy_end;
   assign busy_end = (state == ST_PROG && step == PAGE_LAST)
      || (state == ST_ERASE && !pw_mode && step == (sect_mode ? SECT_LAST : PAGE_LAST));
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         WIP_OUT <= 1'b0;
      else if (!run)
         WIP_OUT <= 1'b0;
      else if (go_load || go_erase)
         WIP_OUT <= 1'b1; // see RQ14
      else if (busy_end)
         WIP_OUT <= 1'b0;
   end

   // latch drops on completion of any modify command or reset pin
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         write_enable_latch <= 1'b0;
      else if (!run || busy_end)
         write_enable_latch <= 1'b0;
      else if (start_ok && byte_cnt == 3'h1 && opcode == OP_WRITE_ENABLE_CMD)
         write_enable_latch <= 1'b1; // see RQ22
      else if (start_ok && byte_cnt == 3'h1 && opcode == OP_WRDI)
         write_enable_latch <= 1'b0;
   end

   //==================================================================
   // serial output: status readback, always served even while busy
   logic [7:0] status;
   logic rdsr;
   always_comb
   begin
      status = 8'h00;
      status[ST_WIP_BIT] = WIP_OUT;
      status[ST_WEL_BIT] = write_enable_latch;
   end
   assign rdsr = active && byte_cnt != 3'h0 && opcode == OP_RDSR;
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         SDO_OUT <= 1'b0;
         SDO_OE_OUT <= 1'b0;
      end
      else
      begin
         SDO_OE_OUT <= rdsr; // see RQ3, RQ5
         if (rdsr && sck_fall)
            SDO_OUT <= status[~bit_cnt]; // see RQ1, RQ20
      end
   end

   //==================================================================
   // checks
   a_sdo_fall_only: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ1
      $changed(SDO_OUT) |-> $past(sck_fall))
      else $error("output changed without a clock fall");
   a_deselect_tristate: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ3
      CS_N_IN |=> !SDO_OE_OUT)
      else $error("output driven while deselected");
   a_reset_pin_quiet: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ5
      !HW_RESET_N_IN ##1 !HW_RESET_N_IN |-> !SDO_OE_OUT && !armed)
      else $error("output driven during reset pin");
   a_reset_abort: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ6
      !HW_RESET_N_IN |=> state == ST_IDLE ##1 !ARR_REQ_OUT.we)
      else $error("cycle not aborted by reset pin");
   a_wp_lock: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ7
      (state == ST_IDLE && protected_tgt) |=> state == ST_IDLE)
      else $error("locked page modified");
   a_wip_tracks: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ14
      $rose(WIP_OUT) |-> ##1 state != ST_IDLE)
      else $error("busy flag without cycle");
   a_wel_needed: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ22
      (state == ST_IDLE ##1 state != ST_IDLE) |-> $past(write_enable_latch, 2))
      else $error("cycle started without enable latch");
   a_byte_boundary: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ21
      $rose(WIP_OUT) |-> $past(bit_cnt) == 3'h0)
      else $error("cycle started off byte boundary");
   a_unarmed_idle: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ4
      !armed |=> !$rose(WIP_OUT) && !$rose(write_enable_latch))
      else $error("command taken before select edge");
   a_busy_ignores: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // see RQ23
      (state == ST_PROG && HW_RESET_N_IN) |=> state != ST_LOAD)
      else $error("cycle disturbed while busy");
endmodule : spf_front_end

// File: spf_pkg.sv
// constants and types shared by the serial paged flash front end
//==================================================================
// Summary of operation
// RQ1 - output bit changes only after clock falls
// RQ2 - input bits captured on rising clock edges
// RQ3 - select high deselects, output tri-stated
// RQ4 - no instruction before first select falling edge
// RQ5 - reset pin low holds reset, output tri-stated
// RQ6 - reset pin low aborts running internal cycle
// RQ7 - protect pin low locks lowest 256 pages
// RQ8 - clock modes 0 and 3 both work
// RQ9 - up to 256 bytes within one page
// RQ10 - master sends opcode, three address bytes, data
// RQ11 - data stored from low address byte offset
// RQ12 - select rise starts fill, erase, program
// RQ13 - program clears bits only, write sets any
// RQ14 - busy flag set during internal cycles
// RQ15 - 32 sectors of 256 pages, 256 bytes
// RQ16 - page erase and sector erase supported
// RQ17 - master sends enable then modify sequence
// RQ18 - master should batch bytes per page
// RQ19 - master holds reset low during power-on
// RQ20 - all bytes most significant bit first
// RQ21 - select must rise on byte boundary
// RQ22 - modification needs enable latch set first
// RQ23 - access during internal cycle ignored
// RQ24 - byte index wraps inside the page
package spf_pkg;
   //==================================================================
   // geometry
   localparam int SECTORS = 32;
   localparam int SECTOR_PAGES = 256;
   localparam int PAGE_BYTES = 256;
   localparam int ADDR_W = 21;
   localparam int STEP_W = 17;
   localparam logic [4:0] PROT_SECTOR = 5'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   //==================================================================
   // opcodes
   localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_PW = 8'h0a;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_PE = 8'hdb;
   localparam logic [7:0] OP_SE = 8'hd8;
   //==================================================================
   // byte counter: 1 after opcode, HDR_BYTES once header is in, DATA_PHASE after a data byte
   localparam logic [2:0] HDR_BYTES = 3'h4;
   localparam logic [2:0] DATA_PHASE = 3'h5;
   // status byte layout
   localparam int ST_WIP_BIT = 0;
   localparam int ST_WEL_BIT = 1;
   // last step of each pass
   localparam logic [STEP_W-1:0] LOAD_LAST = 17'h001ff;
   localparam logic [STEP_W-1:0] PAGE_LAST = 17'h000ff;
   localparam logic [STEP_W-1:0] SECT_LAST = 17'h0ffff;
   //==================================================================
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_ERASE, ST_PROG} spf_state_e;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic we;
   } spf_arr_req_s;
endpackage : spf_pkg

// File: spf_master.sv
// bus master model that drives the serial side of the flash front end
`timescale 1ns/1ns
module spf_master
   import spf_pkg::*;
(
   input wire logic clk_in,
   input wire logic sdo_in,
   input wire logic sdo_oe_in,
   output logic sck_out,
   output logic sdi_out,
   output logic cs_n_out
);
   //==================================================================
   // bus state
   bit mode3 = 1'b0;
   logic last = 1'b0;
   // bus idles deselected with the clock low
   initial
   begin
      sck_out = 1'b0;
      sdi_out = 1'b0;
      cs_n_out = 1'b1;
   end
   //==================================================================
   // bit and byte level
   // idle clock level is only moved while deselected
   task automatic set_mode(input bit m3);
      @(negedge clk_in);
      mode3 = m3;
      sck_out = m3;
   endtask : set_mode
   // two system clocks per clock phase, twice the shortest the device takes
   task automatic half();
      repeat (2) @(negedge clk_in);
   endtask : half
   // fall, present data, rise; an undriven line reads as the inverse of last
   task automatic xbit(input logic b, output logic r);
      sck_out = 1'b0;
      sdi_out = b;
      half();
      r = sdo_oe_in ? sdo_in : ~last;
      last = r;
      sck_out = 1'b1;
      half();
   endtask : xbit
   task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
         xbit(b[i], r[i]);
   endtask : xbyte
   //==================================================================
   // frames
   task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [15:0] d,
                       input int nd, input bit extra);
      logic [7:0] r;
      logic x;
      @(negedge clk_in);
      cs_n_out = 1'b0;
      half();
      xbyte(op, r);
      if (op != OP_WRITE_ENABLE_CMD && op != OP_WRDI)
         for (int i = 2; i >= 0; i--)
            xbyte(a[i*8 +: 8], r);
      for (int i = nd - 1; i >= 0; i--)
         xbyte(d[i*8 +: 8], r);
      if (extra)
         xbit(1'b1, x);
      sck_out = mode3;
      half();
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out;
      half();
   endtask : send
   // status read: opcode then one byte shifted out
   task automatic status(output logic [7:0] s);
      @(negedge clk_in);
      cs_n_out = 1'b0;
      half();
      xbyte(OP_RDSR, s);
      xbyte(8'h00, s);
      sck_out = mode3;
      half();
      cs_n_out = 1'b1;
      half();
   endtask : status
endmodule : spf_master

// File: tb.sv
// self-checking testbench of the flash front end
`timescale 1ns/1ns
module tb
   import spf_pkg::*;
;
   //==================================================================
   // signals and array model
   localparam int LIMIT = 95000;
   typedef struct {logic [7:0] op; logic [23:0] a; logic [7:0] d; logic wp; logic [7:0] exp;}
      spf_row_s;
   logic clk, rst = 1'b1, hw_n = 1'b0, wp_n = 1'b1;
   logic sck, sdi, cs_n, sdo, oe, write_in_progress_flag;
   logic [7:0] rdata, s;
   logic [7:0] mem [0:2097151];
   spf_arr_req_s req;
   int n_fail = 0, n_checks = 0, cyc = 0;
   logic locked;
   spf_row_s rows [8] = '{
      '{OP_PW, 24'h010005, 8'h3c, 1'b1, 8'h3c}, '{OP_PP, 24'h010005, 8'hf0, 1'b1, 8'h30},
      '{OP_PW, 24'h010005, 8'hc3, 1'b1, 8'hc3}, '{OP_PE, 24'h010005, 8'h00, 1'b1, 8'hff},
      '{OP_PW, 24'h020007, 8'haa, 1'b1, 8'haa}, '{OP_SE, 24'h020007, 8'h00, 1'b1, 8'hff},
      '{OP_PW, 24'h000010, 8'h55, 1'b0, 8'hff}, '{OP_PW, 24'h000010, 8'h55, 1'b1, 8'h55}};
   // read is combinational, as the array port demands
   assign rdata = mem[req.addr];
   initial
   begin
      for (int j = 0; j < 2097152; j++)
         mem[j] = 8'hff;
   end
   // array takes a write on each rising edge with the strobe up
   always @(posedge clk)
      if (req.we === 1'b1)
         mem[req.addr] <= req.wdata;
   // clock at 25 MHz
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   spf_master host (.clk_in(clk), .sdo_in(sdo), .sdo_oe_in(oe), .sck_out(sck), .sdi_out(sdi),
                    .cs_n_out(cs_n));
   spf_front_end uut (.REF_CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .SDI_IN(sdi),
                      .CS_N_IN(cs_n), .HW_RESET_N_IN(hw_n), .WP_N_IN(wp_n),
                      .ARR_RDATA_IN(rdata), .SDO_OUT(sdo), .SDO_OE_OUT(oe), .WIP_OUT(write_in_progress_flag),
                      .ARR_REQ_OUT(req));
   //==================================================================
   // compare and report
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_byte
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // polls status; a sector pass takes about a thousand polls
   // a refused command leaves the enable latch set, so the caller says what to expect
   task automatic wait_idle(input logic wel_exp);
      s = 8'h01;
      for (int k = 0; k < 2000 && s[0] !== 1'b0; k++)
         host.status(s);
      chk_bit("busy cleared", 1'b0, s[0]);
      chk_bit("enable latch", wel_exp, s[1]);
   endtask : wait_idle
   task automatic write_enable_cmd();
      host.send(OP_WRITE_ENABLE_CMD, 24'h0, 16'h0, 0, 1'b0);
   endtask : write_enable_cmd
   // a hang ends the run as a mismatch
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         n_fail++;
         final_report();
      end
   end
   //==================================================================
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk_bit("output enable", 1'b0, oe);
      chk_bit("busy", 1'b0, write_in_progress_flag);
      @(negedge clk);
      hw_n = 1'b1;
      $display("test reset done");
      foreach (rows[i])
      begin
         @(negedge clk);
         wp_n = rows[i].wp;
         locked = !rows[i].wp && rows[i].a[20:16] == 5'h00;
         write_enable_cmd();
         host.send(rows[i].op, rows[i].a, {8'h00, rows[i].d},
                   (rows[i].op == OP_PE || rows[i].op == OP_SE) ? 0 : 1, 1'b0);
         repeat (3) @(negedge clk);
         chk_bit("busy", !locked, write_in_progress_flag);
         wait_idle(locked);
         chk_byte("array byte", rows[i].exp, mem[rows[i].a[20:0]]);
         $display("test row %0d done", i);
      end
      // without the latch nothing starts
      host.send(OP_PW, 24'h010020, 16'h0077, 1, 1'b0);
      repeat (3) @(negedge clk);
      chk_bit("busy", 1'b0, write_in_progress_flag);
      // frame ends one bit past a byte
      write_enable_cmd();
      host.send(OP_PW, 24'h010020, 16'h0077, 1, 1'b1);
      repeat (3) @(negedge clk);
      chk_bit("busy", 1'b0, write_in_progress_flag);
      chk_byte("array byte", 8'hff, mem[21'h010020]);
      $display("test refusals done");
      // two bytes cross the page end; a command while busy is dropped
      write_enable_cmd();
      host.send(OP_PW, 24'h0100ff, 16'h1122, 2, 1'b0);
      write_enable_cmd();
      host.send(OP_PW, 24'h010050, 16'h0012, 1, 1'b0);
      wait_idle(1'b0);
      chk_byte("last byte", 8'h11, mem[21'h0100ff]);
      chk_byte("wrapped byte", 8'h22, mem[21'h010000]);
      chk_byte("busy target", 8'hff, mem[21'h010050]);
      $display("test wrap done");
      // reset pin in mid cycle
      write_enable_cmd();
      host.send(OP_PW, 24'h010040, 16'h0099, 1, 1'b0);
      host.status(s);
      chk_bit("status busy", 1'b1, s[0]);
      chk_bit("output enable", 1'b0, oe);
      hw_n = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit("busy", 1'b0, write_in_progress_flag);
      chk_bit("output enable", 1'b0, oe);
      hw_n = 1'b1;
      wait_idle(1'b0);
      $display("test abort done");
      // clock idling high
      host.set_mode(1'b1);
      write_enable_cmd();
      host.send(OP_PW, 24'h010060, 16'h005a, 1, 1'b0);
      wait_idle(1'b0);
      chk_byte("array byte", 8'h5a, mem[21'h010060]);
      host.set_mode(1'b0);
      $display("test mode 3 done");
      final_report();
   end
endmodule : tb
